// ### core/mpdci_host.sv
// Controller on the cable modem side that drives the data and control links of the PHYs.
//
// Summary of operation
// R1: PHY pulls block start low with the first nibble of a data block.
// R2: PHY pulls upstream valid low in every cycle carrying valid data.
// R3: Parity goes out with its own nibble and makes the count of ones even.
// R4: This controller holds control valid low while control message data is shown.
// R5: PHY pulls control ready low when it can take a burst description.
// R6: This controller drives the frame sync; both sides get the timestamp clock.
// R7: This controller gives each PHY its own active low register bus select.
// R8: No parity is made or checked on the serial register bus.
// R9: Parity is even and covers data lines only; it is recommended.
// R10: PHY checks downstream parity; an error does not stop transmit data.
// R11: PHY raises an interrupt source on a downstream parity error.
// R12: This controller checks upstream parity; an error does not stop reception.
// R13: This controller reports each upstream parity error to the system.
// R14: PHY checks parity over every nibble of each control message.
// R15: PHY drops the failing control message and all later ones.
// R16: PHY has one active low, level, open drain interrupt output.
// R17: PHY has one pending bit per source, each cleared by software.
// R18: PHY interrupt is the OR of all pending bits.
// R19: PHY makes a constant, ungapped downstream clock in both framing modes.
// R20: First framing mode: downstream clock is a quarter of the line rate.
// R21: First mode: valid low for a 188 byte packet, then high 32 clocks.
// R22: Second mode: clock at quarter payload rate, valid held low always.
// R23: Sync goes low with the first nibble of each packet sync byte.
// R24: Upstream data cannot be throttled; it is taken on every valid clock.
// R25: Parity is judged only in cycles where the valid strobe is low.
`timescale 1ns/10ps
module mpdci_host (
    input wire logic CLK,
    input wire logic RST,
    input wire logic FRAMING_MODE_B,
    input wire logic [mpdci_pkg::BYTE_W-1:0] DN_BYTE,
    input wire logic DN_BYTE_VALID,
    output logic DN_BYTE_READY,
    input wire logic DOWN_LINK_CLOCK,
    output logic [mpdci_pkg::NIB_W-1:0] DOWN_DATA_NIBBLE,
    output logic DOWN_DATA_PARITY,
    output logic DOWN_DATA_VALID_N,
    output logic DOWN_PACKET_SYNC_N,
    output logic DOWN_UNDERRUN,
    input wire logic UPSTREAM_LINK_CLOCK,
    input wire logic UP_BLOCK_START_N,
    input wire logic UP_DATA_VALID_N,
    input wire logic [mpdci_pkg::NIB_W-1:0] UP_DATA_NIBBLE,
    input wire logic UP_DATA_PARITY,
    output logic [mpdci_pkg::NIB_W-1:0] RX_NIBBLE,
    output logic RX_VALID,
    output logic RX_BLOCK_START,
    output logic UP_PARITY_ERROR,
    input wire logic [mpdci_pkg::NIB_W-1:0] CTL_NIBBLE,
    input wire logic CTL_VALID,
    input wire logic CTL_LAST,
    input wire logic CTL_IS_DESC,
    output logic CTL_TAKE,
    output logic [mpdci_pkg::NIB_W-1:0] CTL_MSG_DATA,
    output logic CTL_MSG_PARITY,
    output logic CTL_MSG_VALID_N,
    input wire logic CTL_MSG_READY_N,
    input wire logic TIMESTAMP_CLOCK,
    input wire logic [mpdci_pkg::LOWER_SEL_W-1:0] TS_LOWER_BITS,
    output logic TIMESTAMP_FRAME_SYNC_N,
    input wire logic [mpdci_pkg::NUM_PHY-1:0] REG_SEL_REQ,
    output logic [mpdci_pkg::NUM_PHY-1:0] REG_BUS_SELECT_N
);
    import mpdci_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [2:0] clk_d;
        mpdci_dn_state_type dn_state;
        logic [NIB_CNT_W-1:0] nib_cnt;
        logic [GAP_CNT_W-1:0] gap_cnt;
        logic [NIB_W-1:0] hold;
        logic [NIB_W-1:0] dn_nib;
        logic dn_par;
        logic dn_valid_n;
        logic dn_sync_n;
        logic dn_underrun;
        logic [NIB_W-1:0] rx_nib;
        logic rx_valid;
        logic rx_sob;
        logic up_perr;
        mpdci_ct_state_type ct_state;
        logic [NIB_W-1:0] ct_nib;
        logic ct_par;
        logic ct_valid_n;
        logic ct_take;
        logic [TS_W-1:0] ts_count;
        logic timestamp_frame_sync_n;
        logic [NUM_PHY-1:0] sel_n;
    } mpdci_host_state_type;

    mpdci_host_state_type st;
    mpdci_host_state_type next_st;
    mpdci_fifo_if #(.WIDTH(BYTE_W)) fifo_bus ();
    logic dn_rise;
    logic up_rise;
    logic up_fall;
    logic ts_rise;
    logic dn_pop;
    logic [TS_W-1:0] ts_mask;
    logic [TS_W-1:0] ts_inc;

    // Downstream bytes wait in the buffer until the link clock asks for them.
    mpdci_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .rst(RST),
        .f(fifo_bus.store)
    );

    // Buffer hookup; the pop strobe comes from the downstream sender.
    assign fifo_bus.in_data = DN_BYTE;
    assign fifo_bus.in_valid = DN_BYTE_VALID;
    assign fifo_bus.out_ready = dn_pop;

    // Link clock edges, seen only on the second synchroniser stage.
    assign dn_rise = st.s2[SY_DCLK] & ~st.clk_d[CD_DCLK];
    assign up_rise = st.s2[SY_UCLK] & ~st.clk_d[CD_UCLK];
    assign up_fall = ~st.s2[SY_UCLK] & st.clk_d[CD_UCLK];
    assign ts_rise = st.s2[SY_TCLK] & ~st.clk_d[CD_TCLK];
    assign ts_mask = (TS_W'(1) << TS_LOWER_BITS) - TS_W'(1);
    assign ts_inc = st.ts_count + TS_W'(1);

    // Next state of every sender and receiver of the controller.
    always_comb begin
        logic load;
        logic first;
        logic [BYTE_W-1:0] byte_in;
        load = 1'b0;
        first = 1'b0;
        byte_in = '0;
        next_st = st;
        dn_pop = 1'b0;
        next_st.s1 = {DOWN_LINK_CLOCK, UPSTREAM_LINK_CLOCK, TIMESTAMP_CLOCK,
                      UP_DATA_VALID_N, UP_BLOCK_START_N, UP_DATA_PARITY,
                      CTL_MSG_READY_N, UP_DATA_NIBBLE};
        next_st.s2 = st.s1;
        next_st.clk_d = {st.s2[SY_DCLK], st.s2[SY_UCLK], st.s2[SY_TCLK]};
        next_st.dn_underrun = 1'b0;
        // Downstream sender: outputs change just after the clock edge seen, so the
        // PHY finds them stable at its next rising edge.
        if (dn_rise) begin
            case (st.dn_state)
                DN_WAIT: begin
                    load = FRAMING_MODE_B | fifo_bus.out_valid; // see R22
                    first = 1'b1;
                end
                DN_PKT: begin
                    if (!st.nib_cnt[0]) begin
                        next_st.dn_nib = st.hold;
                        next_st.dn_sync_n = 1'b1;
                        next_st.nib_cnt = st.nib_cnt + 1'b1;
                    end else if (st.nib_cnt == LAST_NIBBLE) begin
                        if (FRAMING_MODE_B) begin
                            load = 1'b1; // see R22
                            first = 1'b1;
                        end else begin
                            next_st.dn_valid_n = 1'b1; // see R21
                            next_st.gap_cnt = '0;
                            next_st.dn_state = DN_GAP;
                        end
                    end else begin
                        load = 1'b1;
                    end
                end
                DN_GAP: begin
                    if (st.gap_cnt == LAST_GAP) begin
                        load = fifo_bus.out_valid; // see R21
                        first = 1'b1;
                        next_st.dn_state = DN_WAIT;
                    end else begin
                        next_st.gap_cnt = st.gap_cnt + 1'b1;
                    end
                end
                default: begin
                    next_st.dn_state = DN_WAIT;
                end
            endcase
            // A new byte: high nibble now, low nibble on the next link clock.
            if (load) begin
                dn_pop = fifo_bus.out_valid;
                byte_in = fifo_bus.out_valid ? fifo_bus.out_data : '0;
                next_st.dn_underrun = ~fifo_bus.out_valid;
                next_st.dn_nib = byte_in[BYTE_W-1:NIB_W];
                next_st.hold = byte_in[NIB_W-1:0];
                next_st.dn_valid_n = 1'b0;
                next_st.dn_sync_n = ~first; // see R23
                next_st.nib_cnt = first ? '0 : st.nib_cnt + 1'b1;
                next_st.dn_state = DN_PKT;
            end
        end
        next_st.dn_par = ^next_st.dn_nib; // see R3 R9
        // Upstream receiver: sampled mid period, on every valid clock, no throttle.
        next_st.rx_valid = 1'b0;
        next_st.up_perr = 1'b0;
        if (up_fall && !st.s2[SY_UDV]) begin
            next_st.rx_valid = 1'b1; // see R24
            next_st.rx_nib = st.s2[SY_DATA_LO +: NIB_W];
            next_st.rx_sob = ~st.s2[SY_SOB];
            next_st.up_perr = ^{st.s2[SY_DATA_LO +: NIB_W], st.s2[SY_UPAR]}; // see R12 R13
        end
        // Control message sender: descriptions wait for ready, others go at once.
        next_st.ct_take = 1'b0;
        if (up_rise) begin
            case (st.ct_state)
                CT_IDLE: begin
                    if (CTL_VALID && !(CTL_IS_DESC && st.s2[SY_URDY])) begin // see R5
                        next_st.ct_nib = CTL_NIBBLE;
                        next_st.ct_valid_n = 1'b0; // see R4
                        next_st.ct_take = 1'b1;
                        next_st.ct_state = CTL_LAST ? CT_END : CT_SEND;
                    end
                end
                CT_SEND: begin
                    if (CTL_VALID) begin
                        next_st.ct_nib = CTL_NIBBLE; // see R4
                        next_st.ct_take = 1'b1;
                        next_st.ct_state = CTL_LAST ? CT_END : CT_SEND;
                    end else begin
                        next_st.ct_valid_n = 1'b1;
                        next_st.ct_state = CT_IDLE;
                    end
                end
                CT_END: begin
                    next_st.ct_valid_n = 1'b1;
                    next_st.ct_state = CT_IDLE;
                end
                default: begin
                    next_st.ct_state = CT_IDLE;
                end
            endcase
        end
        next_st.ct_par = ^next_st.ct_nib; // see R3 R9
        // Timestamp counter; frame sync lasts one period, two before the wrap.
        if (ts_rise) begin
            next_st.ts_count = ts_inc;
            next_st.timestamp_frame_sync_n = ((ts_inc & ts_mask) != (ts_mask - TS_W'(1))); // see R6
        end
        // Register bus selects; more than one request selects nobody.
        if ((REG_SEL_REQ & (REG_SEL_REQ - 1'b1)) == '0) begin
            next_st.sel_n = ~REG_SEL_REQ; // see R7 R8
        end else begin
            next_st.sel_n = SEL_IDLE_N;
        end
    end

    // State register with all link outputs idle after reset.
    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
            st.dn_valid_n <= IDLE_N;
            st.dn_sync_n <= IDLE_N;
            st.ct_valid_n <= IDLE_N;
            st.timestamp_frame_sync_n <= IDLE_N;
            st.sel_n <= SEL_IDLE_N;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register, except ready, which comes from the buffer's room flop.
    assign DN_BYTE_READY = fifo_bus.in_ready; // Buffer's room flop, so no accepted push is lost.
    assign DOWN_DATA_NIBBLE = st.dn_nib;
    assign DOWN_DATA_PARITY = st.dn_par;
    assign DOWN_DATA_VALID_N = st.dn_valid_n;
    assign DOWN_PACKET_SYNC_N = st.dn_sync_n;
    assign DOWN_UNDERRUN = st.dn_underrun;
    assign RX_NIBBLE = st.rx_nib;
    assign RX_VALID = st.rx_valid;
    assign RX_BLOCK_START = st.rx_sob;
    assign UP_PARITY_ERROR = st.up_perr;
    assign CTL_TAKE = st.ct_take;
    assign CTL_MSG_DATA = st.ct_nib;
    assign CTL_MSG_PARITY = st.ct_par;
    assign CTL_MSG_VALID_N = st.ct_valid_n;
    assign TIMESTAMP_FRAME_SYNC_N = st.timestamp_frame_sync_n;
    assign REG_BUS_SELECT_N = st.sel_n;

    // Counts downstream clocks seen with valid high, for the gap check.
    logic [GAP_CNT_W:0] gap_seen;
    always_ff @(posedge CLK) begin
        if (RST || !st.dn_valid_n) begin
            gap_seen <= '0;
        end else if (dn_rise && gap_seen != '1) begin
            gap_seen <= gap_seen + 1'b1;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    property p_dn_parity;
        !DOWN_DATA_VALID_N |-> (^{DOWN_DATA_NIBBLE, DOWN_DATA_PARITY}) == 1'b0;
    endproperty
    a_dn_parity: assert property (p_dn_parity) else $error("downstream parity odd"); // see R3

    property p_dn_gap;
        $fell(DOWN_DATA_VALID_N) && $past(st.dn_state) == DN_GAP |-> gap_seen == 7'd32;
    endproperty
    a_dn_gap: assert property (p_dn_gap) else $error("downstream gap not 32 clocks"); // see R21

    property p_dn_sync;
        !DOWN_PACKET_SYNC_N |-> !DOWN_DATA_VALID_N && st.nib_cnt == '0;
    endproperty
    a_dn_sync: assert property (p_dn_sync) else $error("sync off the first nibble"); // see R23

    property p_dn_len;
        st.dn_state == DN_PKT |-> st.nib_cnt <= LAST_NIBBLE && !DOWN_DATA_VALID_N;
    endproperty
    a_dn_len: assert property (p_dn_len) else $error("packet longer than 188 bytes"); // see R21

    property p_dn_mode_b;
        FRAMING_MODE_B && $past(FRAMING_MODE_B) && st.dn_state != DN_WAIT
            |-> !DOWN_DATA_VALID_N;
    endproperty
    a_dn_mode_b: assert property (p_dn_mode_b) else $error("valid dropped in mode B"); // see R22

    property p_up_err;
        up_fall && !st.s2[SY_UDV] && (^{st.s2[SY_DATA_LO +: NIB_W], st.s2[SY_UPAR]})
            |=> UP_PARITY_ERROR && RX_VALID;
    endproperty
    a_up_err: assert property (p_up_err) else $error("upstream parity error missed"); // see R12

    property p_up_idle;
        UP_PARITY_ERROR |-> RX_VALID ##1 !UP_PARITY_ERROR;
    endproperty
    a_up_idle: assert property (p_up_idle) else $error("parity error outside valid"); // see R25

    property p_ct_ready;
        $fell(CTL_MSG_VALID_N) |-> !($past(CTL_IS_DESC) && $past(st.s2[SY_URDY]));
    endproperty
    a_ct_ready: assert property (p_ct_ready) else $error("description sent while not ready"); // see R5

    property p_ct_gap;
        $rose(CTL_MSG_VALID_N) |-> CTL_MSG_VALID_N [*7];
    endproperty
    a_ct_gap: assert property (p_ct_gap) else $error("control valid gap too short"); // see R4

    property p_ts_fs;
        $fell(TIMESTAMP_FRAME_SYNC_N) |-> (st.ts_count & ts_mask) == ts_mask - TS_W'(1);
    endproperty
    a_ts_fs: assert property (p_ts_fs) else $error("frame sync at wrong count"); // see R6

    property p_sel;
        (~REG_BUS_SELECT_N & (~REG_BUS_SELECT_N - 1'b1)) == '0;
    endproperty
    a_sel: assert property (p_sel) else $error("two PHYs selected"); // see R7
endmodule

// ### inc/mpdci_pkg.sv
// Package with the constants, state types and field positions of the link controller.
package mpdci_pkg;
    // Widths of the data paths and the buffer.
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int NUM_PHY = 2;
    localparam int TS_W = 32;
    localparam int LOWER_SEL_W = 5;
    localparam int NIB_CNT_W = 9;
    localparam int GAP_CNT_W = 6;
    // Transport packet framing on the downstream link.
    localparam int PKT_BYTES = 188;
    localparam int PKT_NIBBLES = 2 * PKT_BYTES;
    localparam int GAP_CLOCKS = 32;
    localparam logic [NIB_CNT_W-1:0] LAST_NIBBLE = NIB_CNT_W'(PKT_NIBBLES - 1);
    localparam logic [GAP_CNT_W-1:0] LAST_GAP = GAP_CNT_W'(GAP_CLOCKS - 1);
    // Clock rates, kept for reference; the bench hard-codes its own delays and does not use them.
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    // Bit positions inside the vector of synchronised pin inputs.
    localparam int SYNC_W = 11;
    localparam int SY_DCLK = 10;
    localparam int SY_UCLK = 9;
    localparam int SY_TCLK = 8;
    localparam int SY_UDV = 7;
    localparam int SY_SOB = 6;
    localparam int SY_UPAR = 5;
    localparam int SY_URDY = 4;
    localparam int SY_DATA_LO = 0;
    // Positions of the delayed link clocks used for edge detection.
    localparam int CD_DCLK = 2;
    localparam int CD_UCLK = 1;
    localparam int CD_TCLK = 0;
    // Values after reset of the active low link outputs.
    localparam logic IDLE_N = 1'b1;
    localparam logic [NUM_PHY-1:0] SEL_IDLE_N = '1;
    // States of the downstream sender and the control message sender.
    typedef enum logic [1:0] {DN_WAIT, DN_PKT, DN_GAP} mpdci_dn_state_type;
    typedef enum logic [1:0] {CT_IDLE, CT_SEND, CT_END} mpdci_ct_state_type;
endpackage

// ### inc/mpdci_fifo_if.sv
// Interface joining the downstream byte buffer to its filling and draining sides.
`timescale 1ns/10ps
interface mpdci_fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport fill (output in_data, output in_valid, input in_ready);
    modport drain (input out_data, input out_valid, output out_ready);
    modport store (input in_data, input in_valid, input out_ready,
                   output in_ready, output out_data, output out_valid);
endinterface

// ### core/mpdci_fifo.sv
// Buffer of bytes with valid and ready on both sides.
`timescale 1ns/10ps
module mpdci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    mpdci_fifo_if.store f
);
    import mpdci_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic room;
        logic avail;
    } mpdci_fifo_state_type;

    mpdci_fifo_state_type st;
    mpdci_fifo_state_type next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Room and fill flags are kept in flip-flops so both sides see clean levels.
    assign push = f.in_valid & st.room;
    assign pop = f.out_ready & st.avail;
    assign f.in_ready = st.room;
    assign f.out_valid = st.avail;
    assign f.out_data = mem[st.rd];

    // Pointer and count update for one push and one pop per cycle.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: next_st.cnt = st.cnt + 1'b1;
            2'b01: next_st.cnt = st.cnt - 1'b1;
            default: next_st.cnt = st.cnt;
        endcase
        next_st.room = (next_st.cnt != FULL_COUNT);
        next_st.avail = (next_st.cnt != '0);
    end

    // State register, empty after reset; room is shown from the first edge after it.
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{wr: '0, rd: '0, cnt: '0, room: 1'b0, avail: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Storage array, written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wr] <= f.in_data;
        end
    end
endmodule

// ### testbench/mpdci_phy_model.sv
// Behavioural model of the PHY pins that face the link controller.
`timescale 1ns/10ps
module mpdci_phy_model (
    input wire logic up_go,
    input wire logic hold_desc,
    output logic down_link_clock,
    output logic upstream_link_clock,
    output logic timestamp_clock,
    output logic up_block_start_n,
    output logic up_data_valid_n,
    output logic [3:0] up_data_nibble,
    output logic up_data_parity,
    output logic ctl_msg_ready_n,
    output logic [7:0] up_sent
);
    // Idle levels before the first link edge.
    initial begin
        down_link_clock = 1'b0;
        upstream_link_clock = 1'b0;
        timestamp_clock = 1'b0;
        up_block_start_n = 1'b1;
        up_data_valid_n = 1'b1;
        up_data_nibble = 4'h0;
        up_data_parity = 1'b1;
        ctl_msg_ready_n = 1'b1;
        up_sent = 8'h00;
    end
    // Free running clocks; the two link clocks never change on the system clock's rising edge.
    always #200 down_link_clock = ~down_link_clock;
    always #48.828 timestamp_clock = ~timestamp_clock;
    initial begin
        #37;
        forever #200 upstream_link_clock = ~upstream_link_clock;
    end
    // Descriptions are welcome only while the bench does not hold them back.
    always @(posedge upstream_link_clock) ctl_msg_ready_n <= hold_desc;
    // Numbered nibbles in blocks of eight, nibble three of each block with bad parity.
    always @(posedge upstream_link_clock) begin
        if (up_go) begin
            up_data_valid_n <= 1'b0;
            up_block_start_n <= (up_sent[2:0] != 3'h0);
            up_data_nibble <= up_sent[3:0];
            up_data_parity <= ^up_sent[3:0] ^ (up_sent[2:0] == 3'h3);
            up_sent <= up_sent + 8'h01;
        end else begin
            up_data_valid_n <= 1'b1;
            up_block_start_n <= 1'b1;
            up_data_nibble <= ~up_data_nibble;
            up_data_parity <= ~^up_data_nibble; // Odd count while idle, which must not be flagged.
        end
    end
endmodule

// ### testbench/mpdci_host_bench.sv
// Self-checking bench for the link controller with a PHY model on the far side.
`timescale 1ns/10ps
module mpdci_host_bench;
    import mpdci_pkg::*;
    typedef struct {logic [1:0] req; logic [1:0] sel_n;} mpdci_row_type;
    mpdci_row_type rows [4] = '{'{2'h0, 2'h3}, '{2'h1, 2'h2}, '{2'h2, 2'h1}, '{2'h3, 2'h3}};
    logic [3:0] ctl_tab [5] = '{4'h3, 4'hC, 4'h5, 4'hA, 4'h6};
    logic clk, rst, mode_b, dn_valid, dn_ready, up_go, hold_desc, tsfs_n, saw_full, ctl_prev;
    logic dclk, uclk, tclk, sob_n, udv_n, upar, rdy_n, rx_valid, rx_sob, perr;
    logic ctl_valid, ctl_last, ctl_desc, ctl_take, cpar, cvalid_n, dpar, dvalid_n, sync_n, under;
    logic [7:0] dn_byte, up_sent;
    logic [3:0] unib, rx_nib, ctl_nib, cdata, dnib, dexp;
    logic [1:0] sel_req, sel_n;
    int mismatches, n_compared, pushed, push_lim, dn_n, gap, rx_n, ck, t, n_under;

    mpdci_host mpdci_host_i (.CLK(clk), .RST(rst), .FRAMING_MODE_B(mode_b),
        .DN_BYTE(dn_byte), .DN_BYTE_VALID(dn_valid), .DN_BYTE_READY(dn_ready),
        .DOWN_LINK_CLOCK(dclk), .DOWN_DATA_NIBBLE(dnib), .DOWN_DATA_PARITY(dpar),
        .DOWN_DATA_VALID_N(dvalid_n), .DOWN_PACKET_SYNC_N(sync_n), .DOWN_UNDERRUN(under),
        .UPSTREAM_LINK_CLOCK(uclk), .UP_BLOCK_START_N(sob_n), .UP_DATA_VALID_N(udv_n),
        .UP_DATA_NIBBLE(unib), .UP_DATA_PARITY(upar), .RX_NIBBLE(rx_nib), .RX_VALID(rx_valid),
        .RX_BLOCK_START(rx_sob), .UP_PARITY_ERROR(perr), .CTL_NIBBLE(ctl_nib),
        .CTL_VALID(ctl_valid), .CTL_LAST(ctl_last), .CTL_IS_DESC(ctl_desc), .CTL_TAKE(ctl_take),
        .CTL_MSG_DATA(cdata), .CTL_MSG_PARITY(cpar), .CTL_MSG_VALID_N(cvalid_n),
        .CTL_MSG_READY_N(rdy_n), .TIMESTAMP_CLOCK(tclk), .TS_LOWER_BITS(5'h14),
        .TIMESTAMP_FRAME_SYNC_N(tsfs_n), .REG_SEL_REQ(sel_req), .REG_BUS_SELECT_N(sel_n));

    mpdci_phy_model mpdci_phy_model_i (.up_go(up_go), .hold_desc(hold_desc),
        .down_link_clock(dclk), .upstream_link_clock(uclk), .timestamp_clock(tclk),
        .up_block_start_n(sob_n), .up_data_valid_n(udv_n), .up_data_nibble(unib),
        .up_data_parity(upar), .ctl_msg_ready_n(rdy_n), .up_sent(up_sent));

    // System clock of 50 ns.
    always #25 clk = ~clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hands one control message over nibble by nibble, waiting for each take.
    task automatic send_ctl(input int first, input int len, input logic desc);
        for (int i = 0; i < len; i++) begin
            ctl_nib <= ctl_tab[first + i];
            ctl_last <= (i == len - 1);
            ctl_desc <= desc;
            ctl_valid <= 1'b1;
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (ctl_take !== 1'b1 && t < 2000);
            chk(8'(t < 2000), 8'h01);
        end
        ctl_valid <= 1'b0;
        @(posedge clk);
    endtask

    // Pushes numbered bytes as fast as the buffer takes them and notes a refusal.
    always @(posedge clk) begin
        if (!rst && dn_valid && dn_ready) pushed = pushed + 1;
        if (!rst && dn_valid && !dn_ready && pushed > 0) saw_full = 1'b1;
        dn_byte <= 8'(pushed);
        dn_valid <= !rst && pushed < push_lim;
    end

    // Samples the downstream link where the PHY does and checks data, sync and gaps.
    always @(posedge dclk) begin
        if (!rst && dn_n < 2 * push_lim) begin
            if (dvalid_n === 1'b0) begin
                dexp = dn_n[0] ? 4'(dn_n >> 1) : 4'(dn_n >> 5);
                chk(8'(dnib), 8'(dexp));
                chk(8'(dpar), 8'(^dexp));
                chk(8'(sync_n), 8'(dn_n % PKT_NIBBLES != 0));
                if (dn_n > 0) chk(8'(gap), 8'((dn_n % PKT_NIBBLES == 0 && !mode_b) ? GAP_CLOCKS : 0));
                dn_n++;
                gap = 0;
            end else begin
                gap++;
            end
        end
    end

    // Counts underruns; received nibbles arrive in order; parity faults flag only with data.
    always @(posedge clk) begin
        if (!rst && under === 1'b1) n_under++;
        if (!rst && rx_valid === 1'b1) begin
            chk(8'(rx_nib), 8'(rx_n % 16));
            chk(8'(rx_sob), 8'(rx_n % 8 == 0));
            chk(8'(perr), 8'(rx_n % 8 == 3));
            rx_n++;
        end else if (!rst && perr !== 1'b0) begin
            chk(8'(perr), 8'h00);
        end
    end

    // Samples control messages on the link rise and checks data, parity and separation.
    always @(posedge uclk) begin
        if (!rst && cvalid_n === 1'b0) begin
            chk(8'(cdata), 8'(ctl_tab[ck]));
            chk(8'(cpar), 8'(^ctl_tab[ck]));
            if (ck == 3) chk(8'(ctl_prev), 8'h01);
            ck++;
        end
        ctl_prev = cvalid_n;
    end

    // Cuts a hang short well after the expected run of about half a millisecond.
    initial begin
        #1500000;
        mismatches++;
        summarize();
    end

    // Main sequence: reset, select table, then the three links together.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {mode_b, dn_valid, up_go, ctl_valid, ctl_last, ctl_desc, saw_full} = '0;
        {dn_byte, ctl_nib, sel_req} = '0;
        hold_desc = 1'b1;
        {mismatches, n_compared, pushed, push_lim, dn_n, gap, rx_n, ck, n_under} = '0;
        repeat (12) @(posedge clk);
        chk(8'({dvalid_n, cvalid_n, sel_n, tsfs_n, sync_n, dn_ready}), 8'h7E);
        rst <= 1'b0;
        foreach (rows[i]) begin
            sel_req <= rows[i].req;
            repeat (2) @(posedge clk);
            chk(8'(sel_n), 8'(rows[i].sel_n));
        end
        up_go <= 1'b1;
        push_lim <= 3 * PKT_BYTES;
        ctl_valid <= 1'b1;
        ctl_desc <= 1'b1;
        ctl_nib <= ctl_tab[0];
        repeat (60) @(posedge clk);
        chk(8'(cvalid_n), 8'h01);
        hold_desc <= 1'b0;
        send_ctl(0, 3, 1'b1);
        send_ctl(3, 2, 1'b0);
        for (t = 0; dn_n <= PKT_NIBBLES + 24 && t < 20000; t++) @(posedge clk);
        mode_b <= 1'b1;
        for (t = 0; dn_n < 2 * push_lim && t < 25000; t++) @(posedge clk);
        chk(8'(dn_n == 2 * push_lim), 8'h01);
        up_go <= 1'b0;
        repeat (60) @(posedge clk);
        chk(8'(rx_n), up_sent);
        chk(8'(ck), 8'h05);
        chk(8'(n_under > 0), 8'h01);
        chk(8'(dvalid_n), 8'h00);
        chk(8'({saw_full, tsfs_n}), 8'h03);
        summarize();
    end
endmodule
